// file: rtl/ccp_pkg.sv
// shared constants and types of the codec control port host
package ccp_pkg;
	localparam int CCP_TICK_CYC = 4;
	localparam logic [7:0] CCP_DEV_WR = 8'h10;
	localparam logic [7:0] CCP_DEV_RD = 8'h20;
	localparam logic [6:0] CCP_TWI_ADDR = 7'h1A;
	localparam logic [6:0] CCP_WIDE_REG = 7'h49;
	localparam int CCP_WIDE_BIT = 8;
	localparam logic [5:0] CCP_SEG_HDR = 6'h10;
	localparam logic [5:0] CCP_SEG_W16 = 6'h10;
	localparam logic [5:0] CCP_SEG_W24 = 6'h18;
	localparam logic [5:0] CCP_SEG_WORD = 6'h09;
	localparam logic [5:0] CCP_SEG_RD = 6'h10;
	localparam logic [3:0] CCP_ACK_BIT = 4'h8;
	localparam logic [2:0] CCP_ST_ADDR_WR = 3'h0;
	localparam logic [2:0] CCP_ST_CTRL = 3'h1;
	localparam logic [2:0] CCP_ST_DATA = 3'h2;
	localparam logic [2:0] CCP_ST_ADDR_RD = 3'h3;
	localparam logic [2:0] CCP_ST_RX_HI = 3'h4;
	localparam logic [2:0] CCP_ST_RX_LO = 3'h5;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_SPI = 7'h02,
		ST_CSUP = 7'h04,
		ST_TSTART = 7'h08,
		ST_TBIT = 7'h10,
		ST_TSTOP = 7'h20,
		ST_DONE = 7'h40
	} ccp_state_t;

	typedef enum logic [2:0] {
		PR_TWI = 3'h1,
		PR_SPI16 = 3'h2,
		PR_SPI24 = 3'h4
	} ccp_proto_t;
endpackage : ccp_pkg

// file: rtl/ccp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ccp_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : ccp_sync

// file: rtl/ccp_host.sv
// host controller for the codec control port: 16-bit spi, 24/32-bit spi and 2-wire
//
// Overview of operation
// [R1] wide spi first byte is 0x10 for writes, 0x20 for reads.
// [R2] 16-bit spi frame: 7-bit address then 9 data bits, msb first.
// [R3] 16-bit spi mode has no read path; reads are refused.
// [R4] 16-bit write commits when chip select rises after last data bit.
// [R5] 24-bit write framed by chip select low, then address byte, register, data.
// [R6] further 9-bit blocks in one 24-bit write go to next addresses.
// [R7] wide spi entered by writing 1 to bit 8 of register 0x049.
// [R8] wide spi left by clearing that bit with a 24-bit write.
// [R9] 32-bit read: device byte, register byte, two data bytes, framed by select.
// [R10] continued spi read clocking returns next addresses, wrapping to 0x00.
// [R11] unassigned addresses in spi read sequence return zero.
// [R12] 2-wire device is slave only, bytes msb first.
// [R13] 2-wire operations start with START and end with STOP.
// [R14] STOP returns the device 2-wire port to standby.
// [R15] transmitter releases data after eight bits; receiver acks low on ninth.
// [R16] 2-wire slave address upper seven bits are 0011010, lsb is direction.
// [R17] direction bit 1 means read, 0 means write.
// [R18] device acks a matching address, leaves line high otherwise.
// [R19] 2-wire write: START, address, control byte, data bytes, STOP, all acked.
// [R20] 2-wire read: address write, control byte, repeated START, address read.
// [R21] device sends bytes while master acks; master ends with STOP.
// [R22] 2-wire read pointer advances per byte and wraps 7Fh to 00h; cur_addr here advances once per two-byte register read.
// [R23] with wide spi set, 24/32-bit spi is used whatever the select pin.
// [R24] 24-bit frame: 8-bit device byte, 7-bit register, 9 data bits.
// [R25] 32-bit read data: register value in low 9 of 16 bits.
// [R26] all spi transfers are msb first.
// [R27] 2-wire control byte: address in upper bits, data bit 8 in lsb.
`timescale 1ns/1ps
module ccp_host
	import ccp_pkg::*;
#(
	parameter int TICK_CYC = CCP_TICK_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [6:0] cmd_addr,
	input wire logic [8:0] cmd_data,
	input wire logic [7:0] cmd_len,
	input wire logic iface_sel,
	output logic data_take,
	output logic rd_valid,
	output logic [8:0] rd_data,
	output logic done,
	output logic fail,
	output logic wide_spi_enable,
	output logic sclk,
	output logic chip_select_low,
	output logic sdio_out,
	output logic sdio_oe,
	input wire logic sdio_in,
	input wire logic so_in
);
	localparam int DIV_W = $clog2(TICK_CYC) + 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);

	ccp_state_t state, next_state;
	ccp_proto_t proto, next_proto;
	logic [DIV_W-1:0] div;
	logic tick;
	logic [1:0] sub, next_sub;
	logic [5:0] seg, next_seg;
	logic [3:0] bcnt, next_bcnt;
	logic [2:0] step, next_step;
	logic [31:0] shreg, next_shreg;
	logic [15:0] rx, next_rx;
	logic hi_bit, next_hi_bit;
	logic hdr, next_hdr;
	logic rd, next_rd;
	logic err, next_err;
	logic [7:0] words, next_words;
	logic [6:0] cur_addr, next_cur_addr;
	logic [8:0] wdata, next_wdata;
	logic next_cmd_ready, next_data_take, next_rd_valid, next_done, next_fail, next_wide;
	logic [8:0] next_rd_data;
	logic next_sclk, next_csn, next_sdio_out, next_sdio_oe;
	logic word_commit;
	logic [1:0] pins_sync;
	logic sda_s, so_s;

	ccp_sync #(.W(2), .RST_VAL(2'h1)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({so_in, sdio_in}),
		.q(pins_sync)
	);
	assign sda_s = pins_sync[0];
	assign so_s = pins_sync[1];

	function automatic logic [7:0] twi_byte(input logic [2:0] s, input logic r, input logic [6:0] a,
		input logic [8:0] d);
		logic [7:0] b;
		b = 8'h00;
		unique case (s)
			CCP_ST_ADDR_WR: b = {CCP_TWI_ADDR, 1'b0};
			CCP_ST_CTRL: b = r ? {a, 1'b0} : {a, d[8]};
			CCP_ST_DATA: b = d[7:0];
			default: b = {CCP_TWI_ADDR, 1'b1};
		endcase
		return b;
	endfunction : twi_byte

	////////////////////////////////////////////////////////////////////////////////
	// bit clock divider
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div <= '0;
		end else begin
			div <= (div == '0) ? DIV_LAST : div - 1'b1;
		end
	end
	assign tick = (div == '0);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer next values
	always_comb begin
		next_state = state;
		next_proto = proto;
		next_sub = sub;
		next_seg = seg;
		next_bcnt = bcnt;
		next_step = step;
		next_shreg = shreg;
		next_rx = rx;
		next_hi_bit = hi_bit;
		next_hdr = hdr;
		next_rd = rd;
		next_err = err;
		next_words = words;
		next_cur_addr = cur_addr;
		next_wdata = wdata;
		next_data_take = 1'b0;
		next_rd_valid = 1'b0;
		next_rd_data = rd_data;
		next_done = 1'b0;
		next_fail = fail;
		next_wide = wide_spi_enable;
		next_sclk = sclk;
		next_csn = chip_select_low;
		next_sdio_out = sdio_out;
		next_sdio_oe = sdio_oe;
		word_commit = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					next_rd = cmd_read;
					next_cur_addr = cmd_addr;
					next_wdata = cmd_data;
					next_words = cmd_len;
					next_sub = 2'h0;
					next_err = 1'b0;
					next_hdr = cmd_read;
					if (wide_spi_enable) begin // R23
						next_proto = PR_SPI24;
						next_state = ST_SPI;
						next_csn = 1'b0; // R5 R9
						next_shreg = cmd_read ? {CCP_DEV_RD, 1'b0, cmd_addr, 16'h0000} // R1 R9
							: {CCP_DEV_WR, cmd_addr, cmd_data, 8'h00}; // R1 R24
						next_seg = cmd_read ? CCP_SEG_HDR : CCP_SEG_W24;
					end else if (iface_sel) begin
						next_proto = PR_SPI16;
						if (cmd_read) begin
							next_err = 1'b1; // R3
							next_state = ST_DONE;
						end else begin
							next_state = ST_SPI;
							next_csn = 1'b0;
							next_words = 8'h00;
							next_shreg = {cmd_addr, cmd_data, 16'h0000}; // R2
							next_seg = CCP_SEG_W16;
						end
					end else begin
						next_proto = PR_TWI;
						next_state = ST_TSTART;
						next_step = CCP_ST_ADDR_WR;
					end
				end
			end
			ST_SPI: begin
				if (tick) begin
					unique case (sub)
						2'h0: begin
							next_sclk = 1'b0;
							next_sdio_out = shreg[31]; // R26
							next_sdio_oe = 1'b0;
							next_sub = 2'h1;
						end
						2'h1: begin
							next_sclk = 1'b1;
							next_sub = 2'h2;
						end
						default: begin
							next_sclk = 1'b0;
							next_rx = {rx[14:0], so_s};
							next_shreg = {shreg[30:0], 1'b0};
							next_seg = seg - 1'b1;
							next_sub = 2'h0;
							if (seg == 6'h01) begin
								if (hdr) begin
									next_hdr = 1'b0;
									next_seg = CCP_SEG_RD; // R9
								end else begin
									if (rd) begin
										next_rd_valid = 1'b1;
										next_rd_data = {rx[7:0], so_s}; // R25 R11
									end else begin
										word_commit = 1'b1;
									end
									next_cur_addr = cur_addr + 1'b1; // R6 R10
									if (words != 8'h00) begin
										next_words = words - 1'b1;
										if (rd) begin
											next_seg = CCP_SEG_RD; // R10
										end else begin
											next_seg = CCP_SEG_WORD; // R6
											next_shreg = {cmd_data, 23'h000000};
											next_wdata = cmd_data;
											next_data_take = 1'b1;
										end
									end else begin
										next_state = ST_CSUP;
									end
								end
							end
						end
					endcase
				end
			end
			ST_CSUP: begin
				if (tick) begin
					if (!chip_select_low) begin
						next_csn = 1'b1; // R4 R5
						next_sdio_out = 1'b1;
						next_sdio_oe = 1'b1;
					end else begin
						next_sclk = 1'b1;
						next_state = ST_DONE;
					end
				end
			end
			ST_TSTART: begin
				if (tick) begin
					unique case (sub)
						2'h0: begin
							next_sclk = 1'b0;
							next_sdio_out = 1'b0;
							next_sdio_oe = 1'b1;
							next_sub = 2'h1;
						end
						2'h1: begin
							next_sclk = 1'b1;
							next_sub = 2'h2;
						end
						2'h2: begin
							next_sdio_oe = 1'b0; // R13
							next_sub = 2'h3;
						end
						default: begin
							next_sclk = 1'b0;
							next_shreg = {twi_byte(step, rd, cur_addr, wdata), 24'h000000}; // R16 R20
							next_bcnt = 4'h0;
							next_sub = 2'h0;
							next_state = ST_TBIT;
						end
					endcase
				end
			end
			ST_TBIT: begin
				if (tick) begin
					unique case (sub)
						2'h0: begin
							next_sdio_out = 1'b0;
							if (bcnt != CCP_ACK_BIT) begin
								next_sdio_oe = (step <= CCP_ST_ADDR_RD) ? shreg[31] : 1'b1; // R12
							end else if (step <= CCP_ST_ADDR_RD) begin
								next_sdio_oe = 1'b1; // R15
							end else begin
								next_sdio_oe = (step == CCP_ST_RX_LO) && (words == 8'h00); // R15 R21
							end
							next_sub = 2'h1;
						end
						2'h1: begin
							next_sclk = 1'b1;
							next_sub = 2'h2;
						end
						default: begin
							next_sclk = 1'b0;
							next_sub = 2'h0;
							if (bcnt != CCP_ACK_BIT) begin
								next_rx = {rx[14:0], sda_s};
								next_shreg = {shreg[30:0], 1'b0};
								next_bcnt = bcnt + 1'b1;
							end else begin
								next_bcnt = 4'h0;
								if (step <= CCP_ST_ADDR_RD) begin
									if (sda_s) begin
										next_err = 1'b1; // R18
										next_state = ST_TSTOP;
									end else begin
										unique case (step)
											CCP_ST_ADDR_WR: next_step = CCP_ST_CTRL;
											CCP_ST_CTRL: next_step = rd ? CCP_ST_ADDR_RD : CCP_ST_DATA; // R19 R20
											CCP_ST_DATA: next_step = CCP_ST_DATA;
											default: next_step = CCP_ST_RX_HI; // R17
										endcase
										if (step == CCP_ST_DATA) begin
											word_commit = 1'b1; // R19
											next_state = ST_TSTOP;
										end else if (step == CCP_ST_CTRL && rd) begin
											next_state = ST_TSTART; // R20
										end
										next_shreg = {twi_byte(next_step, rd, cur_addr, wdata), 24'h000000}; // R27
									end
								end else if (step == CCP_ST_RX_HI) begin
									next_hi_bit = rx[0];
									next_step = CCP_ST_RX_LO;
								end else begin
									next_rd_valid = 1'b1;
									next_rd_data = {hi_bit, rx[7:0]};
									next_cur_addr = cur_addr + 1'b1; // R22
									if (words == 8'h00) begin
										next_state = ST_TSTOP; // R21
									end else begin
										next_words = words - 1'b1;
										next_step = CCP_ST_RX_HI;
									end
								end
							end
						end
					endcase
				end
			end
			ST_TSTOP: begin
				if (tick) begin
					unique case (sub)
						2'h0: begin
							next_sdio_out = 1'b0;
							next_sdio_oe = 1'b0;
							next_sub = 2'h1;
						end
						2'h1: begin
							next_sclk = 1'b1;
							next_sub = 2'h2;
						end
						default: begin
							next_sdio_oe = 1'b1; // R13 R14
							next_sub = 2'h0;
							next_state = ST_DONE;
						end
					endcase
				end
			end
			default: begin
				next_done = 1'b1;
				next_fail = err;
				next_state = ST_IDLE;
			end
		endcase
		if (word_commit && cur_addr == CCP_WIDE_REG) begin
			next_wide = wdata[CCP_WIDE_BIT]; // R7 R8
		end
		next_cmd_ready = (next_state == ST_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			proto <= PR_SPI16;
			sub <= 2'h0;
			seg <= 6'h00;
			bcnt <= 4'h0;
			step <= 3'h0;
			shreg <= 32'h00000000;
			rx <= 16'h0000;
			hi_bit <= 1'b0;
			hdr <= 1'b0;
			rd <= 1'b0;
			err <= 1'b0;
			words <= 8'h00;
			cur_addr <= 7'h00;
			wdata <= 9'h000;
			cmd_ready <= 1'b0;
			data_take <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 9'h000;
			done <= 1'b0;
			fail <= 1'b0;
			wide_spi_enable <= 1'b0;
			sclk <= 1'b1;
			chip_select_low <= 1'b1;
			sdio_out <= 1'b1;
			sdio_oe <= 1'b1;
		end else begin
			state <= next_state;
			proto <= next_proto;
			sub <= next_sub;
			seg <= next_seg;
			bcnt <= next_bcnt;
			step <= next_step;
			shreg <= next_shreg;
			rx <= next_rx;
			hi_bit <= next_hi_bit;
			hdr <= next_hdr;
			rd <= next_rd;
			err <= next_err;
			words <= next_words;
			cur_addr <= next_cur_addr;
			wdata <= next_wdata;
			cmd_ready <= next_cmd_ready;
			data_take <= next_data_take;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
			done <= next_done;
			fail <= next_fail;
			wide_spi_enable <= next_wide;
			sclk <= next_sclk;
			chip_select_low <= next_csn;
			sdio_out <= next_sdio_out;
			sdio_oe <= next_sdio_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic commit_wide;
	assign commit_wide = word_commit && (cur_addr == CCP_WIDE_REG);

	sequence s_start_hold;
		(sclk && !sdio_oe)[*4] ##1 !sclk;
	endsequence

	sequence s_stop_done;
		(sclk && sdio_oe && state == ST_DONE) ##1 (state == ST_IDLE && done);
	endsequence

	a_idle_lines: assert property ((state == ST_IDLE) |-> chip_select_low && sdio_oe && sclk) // R5
		else $error("lines not idle in idle state");
	a_spi_select: assert property ((state == ST_SPI) |-> !chip_select_low) // R9
		else $error("chip select high during spi frame");
	a_start_edge: assert property ((state == ST_TSTART && sub == 2'h2 && tick) |=> s_start_hold) // R13
		else $error("start condition malformed");
	a_stop_edge: assert property ((state == ST_TSTOP && sub == 2'h2 && tick) |=> s_stop_done) // R14
		else $error("stop condition malformed");
	a_cs_commit: assert property ((state == ST_CSUP && tick && !chip_select_low) |=> chip_select_low && !sclk) // R4
		else $error("chip select not raised with clock low at frame end");
	a_cs_done: assert property ((state == ST_CSUP && tick && chip_select_low) |=> sclk ##1 done) // R5
		else $error("frame end not followed by done");
	a_read16_refused: assert property ((cmd_valid && cmd_ready && cmd_read && iface_sel && !wide_spi_enable)
		|-> ##2 (done && fail)) // R3
		else $error("16-bit spi read not refused");
	a_wide_track: assert property ($changed(wide_spi_enable) |-> $past(commit_wide)) // R8
		else $error("wide spi flag changed without register write");
	a_ack_release: assert property ((state == ST_TBIT && bcnt == CCP_ACK_BIT && step <= CCP_ST_ADDR_RD && sub == 2'h2)
		|-> sdio_oe) // R15
		else $error("host drives data during device ack");
	a_twi_stable: assert property ((state == ST_TBIT && sclk) |-> $stable(sdio_oe)) // R12
		else $error("data changed while clock high");
	a_dev_byte: assert property ((state == ST_SPI && $past(state == ST_IDLE) && proto == PR_SPI24)
		|-> shreg[31:24] == (rd ? CCP_DEV_RD : CCP_DEV_WR)) // R1
		else $error("wrong spi device address byte");
endmodule : ccp_host

// file: tb/ccp_dev_model.sv
// behavioural codec control port device: spi and 2-wire slave with a register file
`timescale 1ns/1ps
module ccp_dev_model
	import ccp_pkg::*;
(
	input wire logic sclk,
	input wire logic chip_select_low,
	input wire logic sdio,
	input wire logic iface_sel,
	input wire logic alt_addr,
	output logic dev_low,
	output logic so
);
	logic [8:0] regs [128];
	logic [31:0] sh;
	logic [15:0] tx16;
	logic [7:0] dbyte, b, tx;
	logic [6:0] ptr;
	logic [8:0] v;
	logic act, rd, hi, d8;
	int cnt, bc, nb;
	wire wide = regs[CCP_WIDE_REG][CCP_WIDE_BIT];
	wire twi = !wide && !iface_sel && chip_select_low;

	function automatic logic [8:0] rv(input logic [6:0] a);
		return (a[6:4] == 3'h6) ? 9'h000 : regs[a];
	endfunction : rv

	function automatic void wr(input logic [6:0] a, input logic [8:0] d);
		if (a[6:4] != 3'h6) regs[a] = d;
	endfunction : wr

	initial begin
		foreach (regs[i]) regs[i] = 9'(i) ^ 9'h0A5;
		so = 1'b0;
		dev_low = 1'b0;
		act = 1'b0;
	end

	////////////////////////////////////////
	always @(negedge chip_select_low) begin
		cnt = 0;
		dbyte = 8'h00;
	end

	always @(posedge sclk) if (!chip_select_low) begin
		sh = {sh[30:0], sdio};
		cnt++;
		if (cnt == 8) dbyte = sh[7:0];
		if (wide && dbyte == CCP_DEV_WR) begin
			if (cnt == 15) ptr = sh[6:0];
			if (cnt >= 24 && (cnt - 24) % 9 == 0) begin
				wr(ptr, sh[8:0]);
				ptr++;
			end
		end
		if (wide && dbyte == CCP_DEV_RD && cnt == 16) ptr = sh[6:0];
	end

	always @(negedge sclk) if (!chip_select_low && wide && dbyte == CCP_DEV_RD && cnt >= 16) begin
		if ((cnt - 16) % 16 == 0) begin
			tx16 = {7'h00, rv(ptr)};
			ptr++;
		end
		so = tx16[15];
		tx16 = {tx16[14:0], 1'b0};
	end

	always @(posedge chip_select_low) begin
		if (!wide && iface_sel && cnt == 16) wr(sh[15:9], sh[8:0]);
		so = ~so;
	end

	////////////////////////////////////////
	always @(negedge sdio) if (sclk && twi) begin
		act = 1'b1;
		bc = 0;
		nb = 0;
		rd = 1'b0;
	end

	always @(posedge sdio) if (sclk && twi) begin
		act = 1'b0;
		dev_low = 1'b0;
	end

	always @(posedge sclk) if (act) begin
		if (bc < 8) b = {b[6:0], sdio};
		else if (rd && sdio) act = 1'b0;
		bc++;
	end

	always @(negedge sclk) if (act) begin
		if (bc == 8) begin
			if (rd) dev_low = 1'b0;
			else if (nb == 0) begin
				dev_low = (b[7:1] == (alt_addr ? ~CCP_TWI_ADDR : CCP_TWI_ADDR));
				rd = b[0] & dev_low;
				hi = 1'b1;
				act = dev_low;
			end else if (nb == 1) begin
				ptr = b[7:1];
				d8 = b[0];
				dev_low = 1'b1;
			end else begin
				wr(ptr, {d8, b});
				dev_low = 1'b1;
			end
		end else if (bc == 9) begin
			bc = 0;
			nb++;
			dev_low = 1'b0;
			if (rd) begin
				v = rv(ptr);
				tx = hi ? {7'h00, v[8]} : v[7:0];
				if (!hi) ptr++;
				hi = !hi;
				dev_low = ~tx[7];
			end
		end else if (rd) dev_low = ~tx[7 - bc];
	end
endmodule : ccp_dev_model

// file: tb/testbench.sv
// self-checking bench for the codec control port host
`timescale 1ns/1ps
module testbench
	import ccp_pkg::*;
;
	logic clk = 0, sys_rst = 1, cmd_valid = 0, cmd_read = 0, iface_sel = 1, alt = 0;
	logic [6:0] cmd_addr = 7'h00;
	logic [8:0] cmd_data = 9'h000;
	logic [7:0] cmd_len = 8'h00;
	logic cmd_ready, data_take, rd_valid, done, fail, wide_spi_enable, sclk, chip_select_low;
	logic sdio_out, sdio_oe, dev_low, so;
	logic [8:0] rd_data, w [4], rq [$];
	wire sdio = sdio_oe ? !dev_low : sdio_out;
	int miscompares = 0, cmp_count = 0, cyc = 0, nbits = 0;

	always #12.5 clk = ~clk;

	ccp_host #(.TICK_CYC(CCP_TICK_CYC)) DUT (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_len(cmd_len), .iface_sel(iface_sel), .data_take(data_take), .rd_valid(rd_valid),
		.rd_data(rd_data), .done(done), .fail(fail), .wide_spi_enable(wide_spi_enable), .sclk(sclk),
		.chip_select_low(chip_select_low), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdio_in(sdio), .so_in(so));
	ccp_dev_model M (.sclk(sclk), .chip_select_low(chip_select_low), .sdio(sdio), .iface_sel(iface_sel),
		.alt_addr(alt), .dev_low(dev_low), .so(so));

	always @(negedge clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
	always @(posedge sclk) if (chip_select_low === 1'b0) nbits++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			results();
		end
	end

	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			miscompares++;
		end
	endtask : chk

	task automatic op(input logic rd, input logic [6:0] a, input logic [7:0] len);
		nbits = 0;
		rq.delete();
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_addr <= a;
		cmd_data <= w[0];
		cmd_len <= len;
		do @(negedge clk); while (cmd_ready !== 1'b1);
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (int i = 1; i <= len && !rd; i++) begin
			cmd_data <= w[i];
			do @(negedge clk); while (data_take !== 1'b1);
			@(posedge clk);
		end
		do @(negedge clk); while (done !== 1'b1);
	endtask : op

	task automatic t_spi16();
		w[0] = 9'h1A5;
		op(1'b0, 7'h05, 8'h00);
		chk("bits", 9'h010, 9'(nbits));
		chk("reg05", 9'h1A5, M.regs[5]);
		op(1'b1, 7'h05, 8'h00);
		chk("fail", 9'h001, {8'h00, fail});
		chk("bits", 9'h000, 9'(nbits));
		w[0] = 9'h100;
		op(1'b0, CCP_WIDE_REG, 8'h00);
		chk("wide", 9'h001, {8'h00, wide_spi_enable});
		$display("test spi16 done");
	endtask : t_spi16

	task automatic t_wide();
		@(posedge clk);
		iface_sel <= 1'b0;
		w[0] = 9'h111;
		w[1] = 9'h0F0;
		w[2] = 9'h1E1;
		op(1'b0, 7'h7E, 8'h02);
		chk("bits", 9'h02A, 9'(nbits));
		chk("reg7e", 9'h111, M.regs[7'h7E]);
		chk("reg7f", 9'h0F0, M.regs[7'h7F]);
		chk("reg00", 9'h1E1, M.regs[0]);
		op(1'b1, 7'h7F, 8'h01);
		chk("bits", 9'h030, 9'(nbits));
		chk("count", 9'h002, 9'(rq.size()));
		chk("rd7f", 9'h0F0, rq[0]);
		chk("rd00", 9'h1E1, rq[1]);
		op(1'b1, 7'h60, 8'h00);
		chk("rd60", 9'h000, rq[0]);
		w[0] = 9'h000;
		op(1'b0, CCP_WIDE_REG, 8'h00);
		chk("wide", 9'h000, {8'h00, wide_spi_enable});
		$display("test wide done");
	endtask : t_wide

	task automatic t_twi();
		w[0] = 9'h1C3;
		op(1'b0, 7'h12, 8'h00);
		chk("fail", 9'h000, {8'h00, fail});
		chk("reg12", 9'h1C3, M.regs[7'h12]);
		op(1'b1, 7'h7F, 8'h01);
		chk("fail", 9'h000, {8'h00, fail});
		chk("count", 9'h002, 9'(rq.size()));
		chk("rd7f", 9'h0F0, rq[0]);
		chk("rd00", 9'h1E1, rq[1]);
		alt <= 1'b1;
		w[0] = 9'h000;
		op(1'b0, 7'h12, 8'h00);
		chk("nack", 9'h001, {8'h00, fail});
		chk("reg12", 9'h1C3, M.regs[7'h12]);
		alt <= 1'b0;
		op(1'b0, 7'h13, 8'h00);
		chk("reg13", 9'h000, M.regs[7'h13]);
		$display("test twi done");
	endtask : t_twi

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	initial begin
		repeat (5) @(negedge clk);
		chk("ready", 9'h000, {8'h00, cmd_ready});
		chk("idle", 9'h003, {7'h00, sclk, chip_select_low});
		chk("wide0", 9'h000, {8'h00, wide_spi_enable});
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_spi16();
		t_wide();
		t_twi();
		results();
	end
endmodule : testbench
